// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the timer event control block
// Assumes: APB answers with one wait state
// Notes:   Event pulses come from the bench
`timescale 1ns/10ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        prescaler_clk_en, counter_reload, bicapture_mode, flip_a, flip_b;
    logic        timer_input_a, timer_input_b, timer_output_a, timer_output_b;
    logic        counter_tick, input_a_event, input_b_event, onchip_event;
    logic        sw_capture0_req, sw_capture1_req, capture_irq, compare_irq, wrap_irq;
    logic        capture0_event, capture1_event, compare0_match, compare1_match;
    logic        counter_wrap_event, capture0_dma_req, compare0_dma_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, input_function_code, a;
    logic [4:0]  evs;
    logic [7:0]  rd, ne;
    int          err_count, n_checks, n_tick, n_ia, n_ib, n_sw0, n_sw1, n_oev, n_dma;
    localparam logic [7:0] R_IN = tec_pkg::IDX_INPUT_EVENT_CONTROL;
    localparam logic [7:0] R_PS = tec_pkg::IDX_PRESCALER_PRESET;
    localparam logic [7:0] R_OA = tec_pkg::IDX_OUTPUT_A_ACTION;
    localparam logic [7:0] R_OB = tec_pkg::IDX_OUTPUT_B_ACTION;
    localparam logic [7:0] R_FL = tec_pkg::IDX_EVENT_FLAGS;
    localparam logic [7:0] R_MK = tec_pkg::IDX_IRQ_DMA_MASK;
    // Rows: action code, preset level, pin after compare 0
    localparam logic [3:0] ROWS [8] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc, 4'hf};
    assign {capture0_event, capture1_event, compare0_match, compare1_match,
            counter_wrap_event} = evs;
    tec_core tec_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .timer_input_a, .timer_input_b,
        .prescaler_clk_en, .counter_reload, .bicapture_mode, .capture0_event,
        .capture1_event, .compare0_match, .compare1_match, .counter_wrap_event,
        .timer_output_a, .timer_output_b, .counter_tick, .input_a_event, .input_b_event,
        .input_function_code, .sw_capture0_req, .sw_capture1_req, .onchip_event,
        .capture_irq, .compare_irq, .wrap_irq, .capture0_dma_req, .compare0_dma_req);
    tec_pin_model tec_pin_model_inst (.pclk, .presetn, .flip_a, .flip_b, .timer_input_a,
        .timer_input_b);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Pulse counters, sampled mid-cycle
    always @(negedge pclk) begin
        n_tick += int'(counter_tick === 1'b1);
        n_ia += int'(input_a_event === 1'b1);
        n_ib += int'(input_b_event === 1'b1);
        n_sw0 += int'(sw_capture0_req === 1'b1);
        n_sw1 += int'(sw_capture1_req === 1'b1);
        n_oev += int'(onchip_event === 1'b1);
        n_dma += int'(capture0_dma_req === 1'b1) + int'(compare0_dma_req === 1'b1);
    end
    // --------
    // Tasks
    // --------
    task automatic wrap_up();
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            err_count++;
            wrap_up();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask
    task automatic ev(input logic [4:0] m);
        evs <= m;
        @(posedge pclk);
        evs <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        {psel, penable, pwrite, prescaler_clk_en, counter_reload, bicapture_mode} = '0;
        {flip_a, flip_b, presetn} = '0;
        {paddr, pwdata, evs} = '0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 6; k++) rdchk(R_IN + 8'(k), 8'h00);
        for (int o = 0; o < 2; o++) begin
            for (int k = 0; k < 8; k++) begin
                a = ROWS[k];
                wr(o ? R_OB : R_OA, {a[3:2], 5'h1e, a[1]});
                ev(5'b00100);
                chk({7'h00, o ? timer_output_b : timer_output_a}, {7'h00, a[0]});
                rdchk(o ? R_OB : R_OA, {a[3:2], 5'h1e, a[0]});
            end
        end
        prescaler_clk_en <= 1'b1;
        repeat (2) @(posedge pclk);
        n_tick = 0;
        repeat (12) @(posedge pclk);
        chk(8'(n_tick), 8'h0c);
        wr(R_PS, 8'h02);
        rdchk(R_PS, 8'h02);
        repeat (4) @(posedge pclk);
        n_tick = 0;
        repeat (30) @(posedge pclk);
        chk(8'(n_tick), 8'h0a);
        counter_reload <= 1'b1;
        n_oev = 0;
        wr(R_OA, 8'h6e);
        n_tick = 0;
        ev(5'b00110);
        chk({7'h00, timer_output_a}, 8'h01);
        chk(8'(n_oev), 8'h01);
        chk(8'(n_tick), 8'h00);
        wr(R_OA, 8'hfc);
        ev(5'b00100);
        wr(R_OB, 8'hfe);
        ev(5'b00001);
        chk(8'(n_oev), 8'h02);
        wr(R_MK, 8'h0c);
        wr(R_FL, 8'h00);
        ev(5'b00111);
        rdchk(R_FL, 8'h38);
        ev(5'b00100);
        rdchk(R_FL, 8'h3a);
        wr(R_FL, 8'h00);
        ev(5'b10000);
        ev(5'b01000);
        rdchk(R_FL, 8'hc0);
        wr(R_FL, 8'h00);
        wr(R_FL, 8'h80);
        apb(1'b0, R_FL, 8'h00);
        chk(rd & 8'h04, 8'h04);
        chk(8'(n_sw0), 8'h01);
        bicapture_mode <= 1'b1;
        wr(R_FL, 8'h00);
        wr(R_FL, 8'h40);
        chk(8'(n_sw1), 8'h00);
        bicapture_mode <= 1'b0;
        wr(R_FL, 8'h00);
        wr(R_FL, 8'h40);
        chk(8'(n_sw1), 8'h01);
        wr(R_FL, 8'h00);
        wr(R_MK, 8'h01);
        ev(5'b00101);
        chk({6'h00, wrap_irq, compare_irq}, 8'h00);
        wr(R_MK, 8'h85);
        repeat (2) @(posedge pclk);
        chk({6'h00, wrap_irq, compare_irq}, 8'h03);
        wr(R_FL, 8'h00);
        repeat (2) @(posedge pclk);
        chk({6'h00, wrap_irq, compare_irq}, 8'h00);
        wr(R_MK, 8'hf8);
        wr(R_FL, 8'h01);
        ev(5'b10000);
        chk({7'h00, capture_irq}, 8'h00);
        ev(5'b01000);
        chk({7'h00, capture_irq}, 8'h01);
        wr(R_FL, 8'h00);
        ev(5'b10000);
        chk({7'h00, capture_irq}, 8'h01);
        chk(8'(n_dma), 8'h04);
        for (int c = 0; c < 16; c++) begin
            wr(R_IN, {4'(c), 2'(c), 2'(c)});
            chk({4'h0, input_function_code}, 8'(c));
            n_ia = 0;
            n_ib = 0;
            for (int t = 0; t < 2; t++) begin
                {flip_a, flip_b} <= 2'b11;
                @(posedge pclk);
                {flip_a, flip_b} <= 2'b00;
                repeat (8) @(posedge pclk);
            end
            ne = (c % 4 == 0) ? 8'h00 : (c % 4 == 3) ? 8'h02 : 8'h01;
            chk(8'(n_ia), ne);
            chk(8'(n_ib), ne);
        end
        apb(1'b0, 8'hf9, 8'h00);
        chk({7'h00, err}, 8'h01);
        wr(R_PS, 8'h33);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(R_PS, 8'h00);
        wrap_up();
    end
endmodule

// ---- dv/tec_checker.sv ----
// Purpose: Port-level assertions for the timer event control block
// Assumes: One pclk domain, presetn active low
// Notes:   Attached to tec_core by bind
`timescale 1ns/10ps
module tec_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        prescaler_clk_en,
    input wire logic        bicapture_mode,
    input wire logic        compare0_match,
    input wire logic        compare1_match,
    input wire logic        counter_wrap_event,
    input wire logic        timer_input_a,
    input wire logic        timer_output_a,
    input wire logic        timer_output_b,
    input wire logic        counter_tick,
    input wire logic        input_a_event,
    input wire logic        sw_capture0_req,
    input wire logic        sw_capture1_req,
    input wire logic        onchip_event,
    input wire logic        capture_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------
    // Checks
    // --------
    ready_after_take_a: assert property (psel && penable && !pready |=> pready)
        else $error("no pready after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    tick_cause_a: assert property (counter_tick |-> $past(prescaler_clk_en))
        else $error("tick without enable");
    chip_evt_cause_a: assert property (onchip_event |-> $past(compare0_match || counter_wrap_event))
        else $error("event pulse without cause");
    outa_cause_a: assert property ($changed(timer_output_a) |-> $past(compare0_match
        || compare1_match || counter_wrap_event || (psel && penable && pwrite)))
        else $error("output a moved alone");
    outb_cause_a: assert property ($changed(timer_output_b) |-> $past(compare0_match
        || compare1_match || counter_wrap_event || (psel && penable && pwrite)))
        else $error("output b moved alone");
    swcap0_cause_a: assert property (sw_capture0_req |-> $past(psel && penable && pwrite
        && pwdata[7]))
        else $error("capture request without write");
    swcap1_mode_a: assert property (sw_capture1_req |-> !$past(bicapture_mode))
        else $error("capture 1 request in bicapture");
    in_a_edge_a: assert property (input_a_event |-> ($past(timer_input_a, 3)
        != $past(timer_input_a, 4)))
        else $error("input event without edge");
    cover property (sw_capture0_req);
    cover property (onchip_event);
    cover property (capture_irq);
endmodule

bind tec_core tec_checker tec_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .pwdata, .pready, .prescaler_clk_en, .bicapture_mode, .compare0_match, .compare1_match,
    .counter_wrap_event, .timer_input_a, .timer_output_a, .timer_output_b, .counter_tick,
    .input_a_event, .sw_capture0_req, .sw_capture1_req, .onchip_event, .capture_irq);

// ---- dv/tec_pin_model.sv ----
// Purpose: Outside world on the timer input pins
// Assumes: Pins idle low
// Notes:   Each request flips one pin
`timescale 1ns/10ps
module tec_pin_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic flip_a,
    input  wire logic flip_b,
    output logic      timer_input_a,
    output logic      timer_input_b
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_input_a <= 1'b0;
            timer_input_b <= 1'b0;
        end else begin
            timer_input_a <= timer_input_a ^ flip_a;
            timer_input_b <= timer_input_b ^ flip_b;
        end
    end
endmodule

// ---- src/tec_core.sv ----
// Purpose: Timer event, prescaler and output-pin control with APB registers
// Assumes: Counter, capture and compare logic live outside and send pulses
// Notes:   Registers are bytes in the low lanes of aligned words
`timescale 1ns/10ps

// How it works
// - Each input has a two-bit edge field: none, falling, rising, both.
// - Four-bit function code assigns clock, gate, trigger or direction roles to inputs.
// - Preset writable anytime; loaded into prescaler at underflow or counter reload.
// - Reset loads prescaler with zero so it divides by one.
// - Prescaler divides its input clock by preset plus one.
// - Output A has set, toggle, clear, nop actions per event source.
// - Output B uses the same action encoding for its three sources.
// - Coinciding events on one output apply the AND of their action fields.
// - Writing bit zero presets the pin; reading it returns the pin level.
// - Compare-0 match gives one-cycle on-chip event pulse when enabled.
// - Counter wrap gives one on-chip event pulse when enabled in output B.
// - Capture-0 flag sets on capture; writing one while the flag is clear requests software capture.
// - Capture-1 flag likewise, but software capture blocked in bicapture mode.
// - Compare-0, compare-1 and wrap flags set on their events.
// - Capture-0 overrun sets on repeat request while flagged, or software capture.
// - Compare-0 overrun sets on repeat request while compare-0 flag is set.
// - Combine bit makes capture interrupt need both captures, else either.
// - Global enable gates every interrupt request of the timer.
// - DMA masks exist for capture 0 and compare 0; five interrupt masks.
module tec_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_input_a,
    input  wire logic        timer_input_b,
    input  wire logic        prescaler_clk_en,
    input  wire logic        counter_reload,
    input  wire logic        bicapture_mode,
    input  wire logic        capture0_event,
    input  wire logic        capture1_event,
    input  wire logic        compare0_match,
    input  wire logic        compare1_match,
    input  wire logic        counter_wrap_event,
    output logic             timer_output_a,
    output logic             timer_output_b,
    output logic             counter_tick,
    output logic             input_a_event,
    output logic             input_b_event,
    output logic      [3:0]  input_function_code,
    output logic             sw_capture0_req,
    output logic             sw_capture1_req,
    output logic             onchip_event,
    output logic             capture_irq,
    output logic             compare_irq,
    output logic             wrap_irq,
    output logic             capture0_dma_req,
    output logic             compare0_dma_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  in_ctl;
        logic [7:0]  pre_preset;
        logic [7:0]  pre_count;
        logic [7:0]  oa_ctl;
        logic [7:0]  ob_ctl;
        logic [7:0]  flags;
        logic [7:0]  mask;
        logic [1:0]  ina_sync;
        logic [1:0]  inb_sync;
        logic        ina_last;
        logic        inb_last;
        logic        out_a;
        logic        out_b;
        logic        tick;
        logic        ev_a;
        logic        ev_b;
        logic        swc0;
        logic        swc1;
        logic        onchip;
        logic        cap_irq;
        logic        cmp_irq;
        logic        wrp_irq;
        logic        cp0_dma;
        logic        cm0_dma;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } tec_state_t;

    tec_state_t st_q;
    tec_state_t st_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic last);
        logic r;
        r = 1'b0;
        case (sel)
            tec_pkg::EDGE_FALL: r = last & ~now;
            tec_pkg::EDGE_RISE: r = ~last & now;
            tec_pkg::EDGE_BOTH: r = last ^ now;
            default:            r = 1'b0;
        endcase
        return r;
    endfunction

    // Combined action of coinciding events, then applied to the pin
    function automatic logic pin_next(input logic [7:0] ctl, input logic pin,
                                      input logic c0, input logic c1, input logic wr);
        logic [1:0] act;
        logic       r;
        act = tec_pkg::ACT_NOP;
        r   = pin;
        if (c0) act = act & ctl[tec_pkg::POS_ACT_CMP0 +: 2];
        if (c1) act = act & ctl[tec_pkg::POS_ACT_CMP1 +: 2];
        if (wr) act = act & ctl[tec_pkg::POS_ACT_WRAP +: 2];
        case (act)
            tec_pkg::ACT_SET: r = 1'b1;
            tec_pkg::ACT_TOG: r = ~pin;
            tec_pkg::ACT_CLR: r = 1'b0;
            default:          r = pin;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    localparam int         ADDR_IDX_W = 8;
    logic [ADDR_IDX_W-1:0] idx;
    logic                  access;
    logic                  wr_en;
    logic                  mapped;
    logic [7:0]            wbyte;
    logic                  in_a;
    logic                  in_b;
    logic                  underflow;
    logic [7:0]            fl;
    logic                  cp0_req;
    logic                  cm0_req;
    logic                  cap_src;

    always_comb begin
        st_d      = st_q;
        idx       = paddr[9:2];
        access    = psel & penable & ~st_q.ready;
        mapped    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                    (idx >= tec_pkg::IDX_INPUT_EVENT_CONTROL);
        wr_en     = access & pwrite & mapped & pstrb[0];
        wbyte     = pwdata[7:0];
        in_a      = st_q.ina_sync[1];
        in_b      = st_q.inb_sync[1];

        st_d.ready = access;
        st_d.err   = access & ~mapped;

        // Pin synchronisers and edge detection
        st_d.ina_sync = {st_q.ina_sync[0], timer_input_a};
        st_d.inb_sync = {st_q.inb_sync[0], timer_input_b};
        st_d.ina_last = in_a;
        st_d.inb_last = in_b;
        st_d.ev_a = edge_hit(st_q.in_ctl[tec_pkg::POS_EDGE_A +: 2], in_a,
                             st_q.ina_last);
        st_d.ev_b = edge_hit(st_q.in_ctl[tec_pkg::POS_EDGE_B +: 2], in_b,
                             st_q.inb_last);

        // Prescaler: count down from preset, tick on underflow
        underflow   = prescaler_clk_en && (st_q.pre_count == 8'h00);
        st_d.tick   = underflow;
        if (counter_reload || underflow) begin
            st_d.pre_count = st_q.pre_preset;
        end else if (prescaler_clk_en) begin
            st_d.pre_count = st_q.pre_count - 8'h01;
        end

        // Output pins
        st_d.out_a = pin_next(st_q.oa_ctl, st_q.out_a, compare0_match, compare1_match,
                              counter_wrap_event);
        st_d.out_b = pin_next(st_q.ob_ctl, st_q.out_b, compare0_match, compare1_match,
                              counter_wrap_event);

        // On-chip event pulse
        st_d.onchip = (compare0_match & st_q.oa_ctl[tec_pkg::POS_EVENT_EN])
                    | (counter_wrap_event & st_q.ob_ctl[tec_pkg::POS_EVENT_EN]);

        st_d.swc0 = 1'b0;
        st_d.swc1 = 1'b0;
        fl = st_q.flags;

        // Register writes
        if (wr_en) begin
            case (idx)
                tec_pkg::IDX_INPUT_EVENT_CONTROL: st_d.in_ctl = wbyte;
                tec_pkg::IDX_PRESCALER_PRESET:    st_d.pre_preset = wbyte;
                tec_pkg::IDX_OUTPUT_A_ACTION: begin
                    st_d.oa_ctl = wbyte;
                    st_d.out_a  = wbyte[tec_pkg::POS_PRESET];
                end
                tec_pkg::IDX_OUTPUT_B_ACTION: begin
                    st_d.ob_ctl = wbyte;
                    st_d.out_b  = wbyte[tec_pkg::POS_PRESET];
                end
                tec_pkg::IDX_EVENT_FLAGS: begin
                    // Ones on clear capture flags request captures; others write through
                    fl = wbyte;
                    fl[tec_pkg::POS_CP0] = st_q.flags[tec_pkg::POS_CP0];
                    fl[tec_pkg::POS_CP1] = st_q.flags[tec_pkg::POS_CP1];
                    if (!wbyte[tec_pkg::POS_CP0]) fl[tec_pkg::POS_CP0] = 1'b0;
                    if (!wbyte[tec_pkg::POS_CP1]) fl[tec_pkg::POS_CP1] = 1'b0;
                    if (wbyte[tec_pkg::POS_CP0] && !st_q.flags[tec_pkg::POS_CP0]) begin
                        st_d.swc0 = 1'b1;
                        fl[tec_pkg::POS_OVR_CP0] = 1'b1;
                    end
                    if (wbyte[tec_pkg::POS_CP1] && !st_q.flags[tec_pkg::POS_CP1] &&
                        !bicapture_mode) begin
                        st_d.swc1 = 1'b1;
                    end
                end
                tec_pkg::IDX_IRQ_DMA_MASK: st_d.mask = wbyte;
                default: ;
            endcase
        end

        // Hardware sets win over the write above
        cp0_req = capture0_event & (st_q.mask[tec_pkg::POS_CP0_IRQ] |
                                    st_q.mask[tec_pkg::POS_CP0_DMA]);
        cm0_req = compare0_match & (st_q.mask[tec_pkg::POS_CM0_IRQ] |
                                    st_q.mask[tec_pkg::POS_CM0_DMA]);
        if (cp0_req && st_q.flags[tec_pkg::POS_CP0]) fl[tec_pkg::POS_OVR_CP0] = 1'b1;
        if (cm0_req && st_q.flags[tec_pkg::POS_CM0]) fl[tec_pkg::POS_OVR_CM0] = 1'b1;
        if (capture0_event)     fl[tec_pkg::POS_CP0] = 1'b1;
        if (capture1_event)     fl[tec_pkg::POS_CP1] = 1'b1;
        if (compare0_match)     fl[tec_pkg::POS_CM0] = 1'b1;
        if (compare1_match)     fl[tec_pkg::POS_CM1] = 1'b1;
        if (counter_wrap_event) fl[tec_pkg::POS_OUF] = 1'b1;
        st_d.flags = fl;

        // Interrupt requests from current flags; DMA requests from this cycle's events
        cap_src = st_q.flags[tec_pkg::POS_COMBINE] ?
                  ((st_q.flags[tec_pkg::POS_CP0] & st_q.mask[tec_pkg::POS_CP0_IRQ]) &
                   (st_q.flags[tec_pkg::POS_CP1] & st_q.mask[tec_pkg::POS_CP1_IRQ])) :
                  ((st_q.flags[tec_pkg::POS_CP0] & st_q.mask[tec_pkg::POS_CP0_IRQ]) |
                   (st_q.flags[tec_pkg::POS_CP1] & st_q.mask[tec_pkg::POS_CP1_IRQ]));
        st_d.cap_irq = st_q.mask[tec_pkg::POS_GLOBAL_TIMER_IRQ_ENABLE] & cap_src;
        st_d.cmp_irq = st_q.mask[tec_pkg::POS_GLOBAL_TIMER_IRQ_ENABLE] &
                       ((st_q.flags[tec_pkg::POS_CM0] & st_q.mask[tec_pkg::POS_CM0_IRQ]) |
                        (st_q.flags[tec_pkg::POS_CM1] & st_q.mask[tec_pkg::POS_CM1_IRQ]));
        st_d.wrp_irq = st_q.mask[tec_pkg::POS_GLOBAL_TIMER_IRQ_ENABLE] & st_q.flags[tec_pkg::POS_OUF] &
                       st_q.mask[tec_pkg::POS_WRAP_IRQ];
        st_d.cp0_dma = capture0_event & st_q.mask[tec_pkg::POS_CP0_DMA];
        st_d.cm0_dma = compare0_match & st_q.mask[tec_pkg::POS_CM0_DMA];

        // Read data
        st_d.rdata = 32'h0000_0000;
        if (access && !pwrite && mapped) begin
            case (idx)
                tec_pkg::IDX_INPUT_EVENT_CONTROL: st_d.rdata[7:0] = st_q.in_ctl;
                tec_pkg::IDX_PRESCALER_PRESET:    st_d.rdata[7:0] = st_q.pre_preset;
                tec_pkg::IDX_OUTPUT_A_ACTION:
                    st_d.rdata[7:0] = {st_q.oa_ctl[7:1], st_q.out_a};
                tec_pkg::IDX_OUTPUT_B_ACTION:
                    st_d.rdata[7:0] = {st_q.ob_ctl[7:1], st_q.out_b};
                tec_pkg::IDX_EVENT_FLAGS:         st_d.rdata[7:0] = st_q.flags;
                tec_pkg::IDX_IRQ_DMA_MASK:        st_d.rdata[7:0] = st_q.mask;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q            <= '0;
            st_q.in_ctl     <= tec_pkg::RST_INPUT_EVENT_CONTROL;
            st_q.pre_preset <= tec_pkg::RST_PRESCALER_PRESET;
            st_q.pre_count  <= tec_pkg::RST_PRESCALER_COUNT;
            st_q.oa_ctl     <= tec_pkg::RST_OUTPUT_ACTION;
            st_q.ob_ctl     <= tec_pkg::RST_OUTPUT_ACTION;
            st_q.flags      <= tec_pkg::RST_EVENT_FLAGS;
            st_q.mask       <= tec_pkg::RST_IRQ_DMA_MASK;
        end else begin
            st_q <= st_d;
        end
    end

    // Input roles decoded outside; code passed on as stored
    assign input_function_code = st_q.in_ctl[tec_pkg::POS_FUNC +: 4];
    assign prdata           = st_q.rdata;
    assign pready           = st_q.ready;
    assign pslverr          = st_q.err;
    assign timer_output_a   = st_q.out_a;
    assign timer_output_b   = st_q.out_b;
    assign counter_tick     = st_q.tick;
    assign input_a_event    = st_q.ev_a;
    assign input_b_event    = st_q.ev_b;
    assign sw_capture0_req  = st_q.swc0;
    assign sw_capture1_req  = st_q.swc1;
    assign onchip_event     = st_q.onchip;
    assign capture_irq      = st_q.cap_irq;
    assign compare_irq      = st_q.cmp_irq;
    assign wrap_irq         = st_q.wrp_irq;
    assign capture0_dma_req = st_q.cp0_dma;
    assign compare0_dma_req = st_q.cm0_dma;

endmodule

// ---- src/tec_pkg.sv ----
// Purpose: Constants for the timer event and I/O control block
// Assumes: APB byte registers, one per aligned word
// Notes:   Offsets are indices; byte address is four times the index
package tec_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INPUT_EVENT_CONTROL = 8'hfa;
    localparam logic [7:0] IDX_PRESCALER_PRESET    = 8'hfb;
    localparam logic [7:0] IDX_OUTPUT_A_ACTION     = 8'hfc;
    localparam logic [7:0] IDX_OUTPUT_B_ACTION     = 8'hfd;
    localparam logic [7:0] IDX_EVENT_FLAGS         = 8'hfe;
    localparam logic [7:0] IDX_IRQ_DMA_MASK        = 8'hff;
    localparam int         ADDR_W                  = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_INPUT_EVENT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PRESCALER_PRESET    = 8'h00;
    localparam logic [7:0] RST_OUTPUT_ACTION       = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS         = 8'h00;
    localparam logic [7:0] RST_IRQ_DMA_MASK        = 8'h00;
    localparam logic [7:0] RST_PRESCALER_COUNT     = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_FUNC        = 4;
    localparam int POS_EDGE_A      = 2;
    localparam int POS_EDGE_B      = 0;
    localparam int POS_ACT_CMP0    = 6;
    localparam int POS_ACT_CMP1    = 4;
    localparam int POS_ACT_WRAP    = 2;
    localparam int POS_EVENT_EN    = 1;
    localparam int POS_PRESET      = 0;
    localparam int POS_CP0         = 7;
    localparam int POS_CP1         = 6;
    localparam int POS_CM0         = 5;
    localparam int POS_CM1         = 4;
    localparam int POS_OUF         = 3;
    localparam int POS_OVR_CP0     = 2;
    localparam int POS_OVR_CM0     = 1;
    localparam int POS_COMBINE     = 0;
    localparam int POS_GLOBAL_TIMER_IRQ_ENABLE       = 7;
    localparam int POS_CP0_DMA     = 6;
    localparam int POS_CP0_IRQ     = 5;
    localparam int POS_CP1_IRQ     = 4;
    localparam int POS_CM0_DMA     = 3;
    localparam int POS_CM0_IRQ     = 2;
    localparam int POS_CM1_IRQ     = 1;
    localparam int POS_WRAP_IRQ    = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] ACT_SET   = 2'h0;
    localparam logic [1:0] ACT_TOG   = 2'h1;
    localparam logic [1:0] ACT_CLR   = 2'h2;
    localparam logic [1:0] ACT_NOP   = 2'h3;

    // Input function codes
    localparam logic [3:0] FN_UP_DOWN_CLK = 4'h8;
    localparam logic [3:0] FN_AUTODISCR   = 4'hc;
endpackage
